// [adsc_consts.svh]
`ifndef ADSC_CONSTS_SVH
`define ADSC_CONSTS_SVH

// ==========================================================================
// Command opcodes
`define ADSC_OP_RESET       8'h06
`define ADSC_OP_START       8'h08
`define ADSC_OP_STOP        8'h0a
`define ADSC_OP_RDATA       8'h12
`define ADSC_OP_READ_HI     3'h1
`define ADSC_OP_WRITE_HI    3'h2

// ==========================================================================
// Register offsets
`define ADSC_REG_DEPTH      32
`define ADSC_ADDR_RATE      5'h02
`define ADSC_ADDR_CONV      5'h03
`define ADSC_ADDR_GPIO      5'h04
`define ADSC_ADDR_POWER     5'h05
`define ADSC_ADDR_REF       5'h06
`define ADSC_ADDR_IROUTE    5'h0d
`define ADSC_ADDR_CURRENT_SOURCE_MAGNITUDE      5'h0e
`define ADSC_ADDR_GAIN      5'h10
`define ADSC_ADDR_INMUX     5'h11
`define ADSC_ADDR_BIAS      5'h12
`define ADSC_REG_WR_MASK    32'h0007607c
`define ADSC_REG_RESET      8'h00

// ==========================================================================
// Field positions
`define ADSC_CONV_SINGLE    4
`define ADSC_CONV_DLY_MSB   2
`define ADSC_POWER_DOWN     7
`define ADSC_GAIN_BYPASS    7
`define ADSC_GAIN_MSB       2

// ==========================================================================
// Timing
`define ADSC_CLK_PERIOD_NS  4
`define ADSC_RATE_SPS       20
`define ADSC_CONV_CYC       (1000000000 / (`ADSC_CLK_PERIOD_NS * `ADSC_RATE_SPS))
`define ADSC_DELAY_US       50
`define ADSC_DELAY_CYC      ((`ADSC_DELAY_US * 1000) / `ADSC_CLK_PERIOD_NS)

`endif

// [adsc_pkg.sv]
package adsc_pkg;
    typedef logic [7:0]         adsc_byte_t;
    typedef logic signed [23:0] adsc_code_t;
    typedef enum logic [2:0] {
        ST_CMD,
        ST_WR,
        ST_RD,
        ST_RDATA,
        ST_SKIP
    } adsc_cmd_st_t;
endpackage

// [adsc_link_if.sv]
interface adsc_link_if;
    import adsc_pkg::*;
    adsc_byte_t       rx_byte;
    logic             rx_valid;
    logic             frame_start;
    adsc_byte_t       tx_byte;
    logic             wr_en;
    logic [4:0]       wr_addr;
    adsc_byte_t       wr_data;
    logic [4:0]       rd_addr;
    adsc_byte_t       rd_data;
    logic             clr;
    logic [31:0][7:0] regs;
    modport shf  (output rx_byte, rx_valid, frame_start, input tx_byte);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, clr, output rd_data, regs);
    modport core (input rx_byte, rx_valid, frame_start, rd_data, regs,
                  output tx_byte, wr_en, wr_addr, wr_data, rd_addr, clr);
endinterface

// [adsc_spi_shift.sv]
module adsc_spi_shift (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic sclk_in,
    input  wire logic cs_n_in,
    input  wire logic mosi_in,
    output logic      miso_out,
    output logic      miso_oe_out,
    adsc_link_if.shf  lnk
);
    import adsc_pkg::*;

    // ======================================================================
    // Pin synchronisers and edge detection
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] mosi_q;
    logic       rise;
    logic       fall;
    logic       active;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_q <= 3'h0;
            cs_q   <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_in};
            cs_q   <= {cs_q[1:0], cs_n_in};
            mosi_q <= {mosi_q[0], mosi_in};
        end
    end

    assign rise   = sclk_q[1] & ~sclk_q[2];
    assign fall   = ~sclk_q[1] & sclk_q[2];
    assign active = ~cs_q[1];
    assign lnk.frame_start = cs_q[2] & ~cs_q[1];

    // ======================================================================
    // Shift registers
    logic [2:0] cnt_q;
    logic [6:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] src;
    adsc_byte_t rx_byte_q;
    logic       rx_valid_q;
    logic       miso_q;
    logic       oe_q;

    assign src = (cnt_q == 3'h0) ? lnk.tx_byte : tx_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q      <= 3'h0;
            rx_q       <= 7'h00;
            tx_q       <= 8'h00;
            rx_byte_q  <= 8'h00;
            rx_valid_q <= 1'b0;
            miso_q     <= 1'b0;
            oe_q       <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            oe_q       <= active;
            if (!active) begin
                cnt_q  <= 3'h0;
                miso_q <= 1'b0;
            end else if (rise) begin
                miso_q <= src[7];
                tx_q   <= {src[6:0], 1'b0};
            end else if (fall) begin
                rx_q  <= {rx_q[5:0], mosi_q[1]};
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    rx_byte_q  <= {rx_q, mosi_q[1]};
                    rx_valid_q <= 1'b1;
                end
            end
        end
    end

    assign lnk.rx_byte  = rx_byte_q;
    assign lnk.rx_valid = rx_valid_q;
    assign miso_out     = miso_q;
    assign miso_oe_out  = oe_q;

    // ======================================================================
    // Checks
    miso_on_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ($changed(miso_q) && active) |-> $past(rise))
        else $error("Output bit changed away from a rising clock edge.");
    byte_on_fall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_valid_q |-> ($past(fall) && $past(cnt_q) == 3'h7))
        else $error("Byte completed without its eighth falling edge.");
endmodule

// [adsc_regmem.sv]
`include "adsc_consts.svh"
module adsc_regmem #(
    parameter int unsigned DEPTH = `ADSC_REG_DEPTH
)(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    adsc_link_if.mem  lnk
);
    import adsc_pkg::*;

    localparam logic [31:0] WR_MASK = `ADSC_REG_WR_MASK;

    if (DEPTH < 19 || DEPTH > 32) begin : g_bad_depth
        $error("Register depth must lie between 19 and 32.");
    end

    // ======================================================================
    // Storage, one entry per address
    // Next values are built per entry and stored by one process.
    // This keeps a single driver on the shared register array.
    wire logic [31:0][7:0] regs_d;

    for (genvar i = 0; i < 32; i++) begin : g_reg
        if (i < DEPTH && WR_MASK[i]) begin : g_rw
            assign regs_d[i] = lnk.clr ? `ADSC_REG_RESET :
                               (lnk.wr_en && lnk.wr_addr == 5'(i)) ? lnk.wr_data
                               : lnk.regs[i];
        end else begin : g_ro
            assign regs_d[i] = `ADSC_REG_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lnk.regs <= {32{`ADSC_REG_RESET}};
        end else begin
            lnk.regs <= regs_d;
        end
    end

    // ======================================================================
    // Registered read port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lnk.rd_data <= 8'h00;
        end else begin
            lnk.rd_data <= lnk.regs[lnk.rd_addr];
        end
    end
endmodule

// [adsc_top.sv]
`include "adsc_consts.svh"
module adsc_top #(
    parameter int unsigned CONV_CYC  = `ADSC_CONV_CYC,
    parameter int unsigned DELAY_CYC = `ADSC_DELAY_CYC
)(
    input  wire logic           ref_clk_in,
    input  wire logic           rst_n_in,
    input  wire logic           sclk_in,
    input  wire logic           cs_n_in,
    input  wire logic           mosi_in,
    output logic                miso_out,
    output logic                miso_oe_out,
    output logic                data_ready_n_out,
    input  wire adsc_pkg::adsc_code_t ratio_in,
    output logic                converting_out,
    output adsc_pkg::adsc_byte_t general_pin_control_out,
    output adsc_pkg::adsc_byte_t reference_select_out,
    output adsc_pkg::adsc_byte_t current_source_routing_out,
    output adsc_pkg::adsc_byte_t current_source_magnitude_out,
    output adsc_pkg::adsc_byte_t amplifier_gain_out,
    output adsc_pkg::adsc_byte_t input_multiplexer_out,
    output adsc_pkg::adsc_byte_t input_bias_control_out
);
    import adsc_pkg::*;

    if (CONV_CYC < 2 || CONV_CYC + DELAY_CYC > 32'h00ffffff) begin : g_bad_time
        $error("Conversion timing does not fit the 24-bit timer.");
    end

    // ======================================================================
    // Reset release
    logic rst_m_q;
    logic rst_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end

    // ======================================================================
    // Serial shifter and register storage
    adsc_link_if lnk ();

    adsc_spi_shift u_shift (
        .clk_in      (ref_clk_in),
        .rst_n_in    (rst_q),
        .sclk_in     (sclk_in),
        .cs_n_in     (cs_n_in),
        .mosi_in     (mosi_in),
        .miso_out    (miso_out),
        .miso_oe_out (miso_oe_out),
        .lnk         (lnk.shf)
    );

    adsc_regmem #(
        .DEPTH (`ADSC_REG_DEPTH)
    ) u_regs (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_q),
        .lnk      (lnk.mem)
    );

    adsc_byte_t rate_reg;
    adsc_byte_t conv_reg;
    adsc_byte_t power_reg;
    adsc_byte_t gain_reg;

    assign rate_reg  = lnk.regs[`ADSC_ADDR_RATE];
    assign conv_reg  = lnk.regs[`ADSC_ADDR_CONV];
    assign power_reg = lnk.regs[`ADSC_ADDR_POWER];
    assign gain_reg  = lnk.regs[`ADSC_ADDR_GAIN];

    // Analog front-end controls come straight from register flops.
    assign general_pin_control_out      = lnk.regs[`ADSC_ADDR_GPIO];
    assign reference_select_out         = lnk.regs[`ADSC_ADDR_REF];
    assign current_source_routing_out   = lnk.regs[`ADSC_ADDR_IROUTE];
    assign current_source_magnitude_out = lnk.regs[`ADSC_ADDR_CURRENT_SOURCE_MAGNITUDE];
    assign amplifier_gain_out           = gain_reg;
    assign input_multiplexer_out        = lnk.regs[`ADSC_ADDR_INMUX];
    assign input_bias_control_out       = lnk.regs[`ADSC_ADDR_BIAS];

    // ======================================================================
    // Command decode
    adsc_cmd_st_t st_q;
    logic         cmd_byte;
    logic         op_reset;
    logic         op_start;
    logic         op_stop;
    logic         op_rdata;
    logic         op_write;
    logic         op_read;
    logic [4:0]   wr_addr_q;
    logic [4:0]   rd_addr_q;
    logic [1:0]   idx_q;

    assign cmd_byte = lnk.rx_valid && st_q == ST_CMD;
    assign op_reset = cmd_byte && lnk.rx_byte == `ADSC_OP_RESET;
    assign op_start = cmd_byte && lnk.rx_byte == `ADSC_OP_START;
    assign op_stop  = cmd_byte && lnk.rx_byte == `ADSC_OP_STOP;
    assign op_rdata = cmd_byte && lnk.rx_byte == `ADSC_OP_RDATA;
    assign op_write = cmd_byte && lnk.rx_byte[7:5] == `ADSC_OP_WRITE_HI;
    assign op_read  = cmd_byte && lnk.rx_byte[7:5] == `ADSC_OP_READ_HI;
    assign lnk.clr  = op_reset;

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= ST_CMD;
        end else if (lnk.frame_start) begin
            st_q <= ST_CMD;
        end else if (cmd_byte) begin
            if (op_write) begin
                st_q <= ST_WR;
            end else if (op_read) begin
                st_q <= ST_RD;
            end else if (op_rdata) begin
                st_q <= ST_RDATA;
            end else begin
                st_q <= ST_SKIP;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            wr_addr_q <= 5'h00;
            rd_addr_q <= 5'h00;
            idx_q     <= 2'h0;
        end else if (lnk.rx_valid) begin
            case (st_q)
                ST_CMD: begin
                    wr_addr_q <= lnk.rx_byte[4:0];
                    rd_addr_q <= lnk.rx_byte[4:0];
                    idx_q     <= 2'h0;
                end
                ST_WR: begin
                    wr_addr_q <= wr_addr_q + 5'h01;
                end
                ST_RD: begin
                    rd_addr_q <= rd_addr_q + 5'h01;
                end
                ST_RDATA: begin
                    idx_q <= idx_q + 2'h1;
                end
                default: begin
                    idx_q <= idx_q;
                end
            endcase
        end
    end

    assign lnk.wr_en   = lnk.rx_valid && st_q == ST_WR;
    assign lnk.wr_addr = wr_addr_q;
    assign lnk.wr_data = lnk.rx_byte;
    assign lnk.rd_addr = rd_addr_q;

    // ======================================================================
    // Conversion timing
    logic        run_q;
    logic [23:0] timer_q;
    logic        delay_on;
    logic        powered;
    logic        conv_pre;
    logic        conv_done;

    assign delay_on  = |conv_reg[`ADSC_CONV_DLY_MSB:0];
    assign powered   = ~power_reg[`ADSC_POWER_DOWN];
    assign conv_pre  = run_q && powered && timer_q == 24'h000001;
    assign conv_done = run_q && powered && timer_q == 24'h000000;
    assign converting_out = run_q;

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            run_q   <= 1'b0;
            timer_q <= 24'h000000;
        end else if (op_reset || op_stop) begin
            run_q   <= 1'b0;
            timer_q <= 24'h000000;
        end else if (op_start) begin
            run_q   <= 1'b1;
            timer_q <= 24'(CONV_CYC - 1);
        end else if (conv_done) begin
            run_q   <= ~conv_reg[`ADSC_CONV_SINGLE];
            timer_q <= 24'(CONV_CYC + (delay_on ? DELAY_CYC : 0) - 1);
        end else if (run_q && powered) begin
            timer_q <= timer_q - 24'h000001;
        end
    end

    // ======================================================================
    // Result scaling
    adsc_code_t        ratio_m_q;
    adsc_code_t        ratio_s_q;
    adsc_code_t        code_q;
    adsc_code_t        out_q;
    logic [2:0]        gain_sh;
    logic signed [31:0] scaled;

    assign gain_sh = gain_reg[`ADSC_GAIN_BYPASS] ? 3'h0 : gain_reg[`ADSC_GAIN_MSB:0];
    assign scaled  = 32'(signed'({{8{ratio_s_q[23]}}, ratio_s_q})) <<< gain_sh;

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            ratio_m_q <= 24'h000000;
            ratio_s_q <= 24'h000000;
        end else begin
            ratio_m_q <= ratio_in;
            ratio_s_q <= ratio_m_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            code_q <= 24'h000000;
        end else if (op_reset) begin
            code_q <= 24'h000000;
        end else if (conv_done) begin
            if (scaled > 32'sh007fffff) begin
                code_q <= 24'h7fffff;
            end else if (scaled < -32'sh00800000) begin
                code_q <= 24'h800000;
            end else begin
                code_q <= scaled[23:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            out_q <= 24'h000000;
        end else if (op_rdata) begin
            out_q <= code_q;
        end
    end

    always_comb begin
        case (st_q)
            ST_RD:    lnk.tx_byte = lnk.rd_data;
            ST_RDATA: begin
                case (idx_q)
                    2'h0:    lnk.tx_byte = out_q[23:16];
                    2'h1:    lnk.tx_byte = out_q[15:8];
                    2'h2:    lnk.tx_byte = out_q[7:0];
                    default: lnk.tx_byte = 8'h00;
                endcase
            end
            default:  lnk.tx_byte = 8'h00;
        endcase
    end

    // ======================================================================
    // Data-ready output
    logic data_ready_n_n_q;

    always_ff @(posedge ref_clk_in or negedge rst_q) begin
        if (!rst_q) begin
            data_ready_n_n_q <= 1'b1;
        end else if (conv_done) begin
            data_ready_n_n_q <= 1'b0;
        end else if (conv_pre || op_rdata || op_reset) begin
            data_ready_n_n_q <= 1'b1;
        end
    end

    assign data_ready_n_out = data_ready_n_n_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_q);

    data_ready_n_falls_a: assert property (conv_done |=> !data_ready_n_out)
        else $error("Data-ready did not fall after a result.");
    data_ready_n_edge_a: assert property (conv_done |-> ##1 $fell(data_ready_n_out))
        else $error("New result gave no falling data-ready edge.");
    soft_reset_a: assert property (op_reset |=> (!run_q && rate_reg == 8'h00))
        else $error("Reset opcode left state behind.");
    write_reg_a: assert property ((lnk.wr_en && wr_addr_q == `ADSC_ADDR_RATE)
        |=> (rate_reg == $past(lnk.rx_byte) && wr_addr_q == `ADSC_ADDR_CONV))
        else $error("Register write missed its address.");
    read_step_a: assert property ((lnk.rx_valid && st_q == ST_RD)
        |=> rd_addr_q == $past(rd_addr_q) + 5'h01)
        else $error("Read address did not advance.");
    start_runs_a: assert property (op_start |=> (run_q && timer_q == 24'(CONV_CYC - 1)))
        else $error("Start opcode did not start conversions.");
    stop_idles_a: assert property (op_stop |=> (!run_q ##1 !conv_done))
        else $error("Stop opcode did not reach standby.");
    rdata_byte_a: assert property (op_rdata |=> (out_q == $past(code_q)
        && lnk.tx_byte == out_q[23:16]))
        else $error("Result fetch sent the wrong first byte.");
    gain_scale_a: assert property ((conv_done && gain_reg == 8'h03
        && ratio_s_q < 24'sh080000 && ratio_s_q > -24'sh080000 && !op_reset)
        |=> code_q == $past(ratio_s_q) * 24'sh000008)
        else $error("Gain of eight not applied to the result.");
    conv_gap_a: assert property ((conv_done && ~conv_reg[`ADSC_CONV_SINGLE]
        && delay_on && !op_stop && !op_reset && !op_start)
        |=> timer_q == 24'(CONV_CYC + DELAY_CYC - 1))
        else $error("Gap between conversions is wrong.");
    power_down_a: assert property ((power_reg[`ADSC_POWER_DOWN] && !op_start
        && !op_stop && !op_reset) |=> $stable(timer_q))
        else $error("Conversion timer ran while powered down.");
endmodule

// [adsc_host_model.sv]
module adsc_host_model
    import adsc_pkg::*;
(
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Host side of the serial link
    // The clock idles low; data is launched on the rise and taken on the fall.
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    task automatic frame(input adsc_byte_t tx[$], output adsc_byte_t rx[$]);
        adsc_byte_t b;
        rx = {};
        cs_n_out = 1'b0;
        #40;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                sclk_out = 1'b1;
                mosi_out = tx[k][i];
                #40;
                b[i] = miso_in;
                sclk_out = 1'b0;
                #40;
            end
            rx.push_back(b);
        end
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #400;
    endtask
endmodule

// [adc_spi_config_and_readout_tb_top.sv]
module adc_spi_config_and_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adsc_pkg::*;
    localparam int CONV = 200;
    localparam int DLY  = 20;
    logic       ref_clk_in = 1'b0;
    logic       rst_n_in   = 1'b0;
    logic       sclk, cs_n, mosi, miso, miso_oe, data_ready_n_n, conv_on;
    adsc_code_t ratio      = '0;
    adsc_byte_t gpc, refs, iroute, current_source_magnitude, gain, inmux, bias;
    adsc_byte_t rx[$];
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cyc        = 0;
    int         n_fall     = 0;
    int         mdl[32];
    int         t0, v;

    always #2 ref_clk_in = ~ref_clk_in;
    always @(negedge data_ready_n_n) n_fall++;

    adsc_top #(.CONV_CYC(CONV), .DELAY_CYC(DLY)) dut_u (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .data_ready_n_out(data_ready_n_n),
        .ratio_in(ratio), .converting_out(conv_on), .general_pin_control_out(gpc),
        .reference_select_out(refs), .current_source_routing_out(iroute),
        .current_source_magnitude_out(current_source_magnitude), .amplifier_gain_out(gain),
        .input_multiplexer_out(inmux), .input_bias_control_out(bias));

    adsc_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));

    // ==========================================================
    // Checking helpers
    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            $display("[FAIL] %0t run did not finish", $time);
            wrap_up();
        end
    end

    // Only the listed registers hold data; the reserved slot stays zero.
    task automatic wr(input int a, input adsc_byte_t d[$]);
        adsc_byte_t q[$];
        q = d;
        q.push_front(8'h40 | 8'(a));
        foreach (d[k]) if ((a + k) inside {[2:6], 13, 14, [16:18]}) mdl[a + k] = d[k];
        host_u.frame(q, rx);
    endtask

    task automatic read_all();
        adsc_byte_t q[$];
        q = {8'h22};
        repeat (17) q.push_back(8'h00);
        host_u.frame(q, rx);
        for (int a = 0; a < 17; a++) chk(rx[a + 1], mdl[a + 2][7:0]);
    endtask

    task automatic fetch();
        @(negedge data_ready_n_n);
        @(negedge ref_clk_in);
        host_u.frame({8'h12, 8'h00, 8'h00, 8'h00}, rx);
        chk({rx[1], rx[2], rx[3]}, 24'(ratio * 8));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(19179));
        foreach (mdl[i]) mdl[i] = 0;
        repeat (3) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        host_u.frame({8'h06}, rx);
        read_all();
        wr(2, {8'h24, 8'h01, 8'h00, 8'h00, 8'h1a});
        wr(13, {8'h4a, 8'h44, 8'h00, 8'h03, 8'h34, 8'h00});
        wr(15, {8'h5a});
        read_all();
        chk({refs, iroute, current_source_magnitude}, 24'h1a4a44);
        chk({gain, inmux, bias}, 24'h033400);
        v = $urandom_range(255);
        wr(4, {8'(v)});
        chk(gpc, v[7:0]);
        wr(4, {8'h00});
        ratio = adsc_code_t'($urandom_range(24'h0fffff));
        host_u.frame({8'h08}, rx);
        chk(conv_on, 1'b1);
        @(negedge data_ready_n_n);
        t0 = cyc;
        @(negedge data_ready_n_n);
        chk(cyc - t0, CONV + DLY);
        repeat (3) begin
            fetch();
            ratio = adsc_code_t'($urandom_range(24'h0fffff));
            @(negedge data_ready_n_n);
        end
        host_u.frame({8'h0a}, rx);
        chk(conv_on, 1'b0);
        v = n_fall;
        repeat (500) @(negedge ref_clk_in);
        chk(n_fall - v, 0);
        host_u.frame({8'h08}, rx);
        fetch();
        // Power-down freezes the running conversion, so no result may appear.
        wr(5, {8'h80});
        v = n_fall;
        repeat (500) @(negedge ref_clk_in);
        chk(n_fall - v, 0);
        host_u.frame({8'h06}, rx);
        foreach (mdl[i]) mdl[i] = 0;
        chk({conv_on, data_ready_n_n, miso_oe}, 3'b010);
        chk({gain, inmux, bias}, 24'h0);
        read_all();
        // Single-shot setting gives one result and then stops.
        wr(3, {8'h10});
        host_u.frame({8'h08}, rx);
        @(negedge data_ready_n_n);
        repeat (CONV + DLY) @(negedge ref_clk_in);
        chk({conv_on, data_ready_n_n}, 2'b00);
        wrap_up();
    end
endmodule
